/* xqed_pkg.sv */
// package for the dual-channel encoder decoder
package xqed_pkg;
  localparam int unsigned XQED_CNT_W      = 32;
  localparam int unsigned XQED_CPR_MOTOR  = 12;
  localparam logic [1:0]  XQED_SYNC_RST   = 2'h0;

  // one encoder's two lines as delivered by the sensor board
  typedef struct packed {
    logic xor_line;
    logic chan_b;
  } xqed_enc_in_type;

  // per-channel decoded status
  typedef struct packed {
    logic fwd_step;
    logic rev_step;
    logic err_pulse;
  } xqed_evt_type;

  typedef enum logic {
    XQED_DIR_NORMAL,
    XQED_DIR_INVERT
  } xqed_dir_type;
endpackage

/* xqed_top.sv */
// two-channel xor quadrature encoder decoder
//
// Summary of operation
// - two independent channels, left and right
// - rebuild A as combined xor B
// - B leading A counts forward, reverse when dir_invert is set
// - every edge counted, twelve per shaft turn, unless A and B move in one sample
// - every combined-line change must be caught
`timescale 1ns/1ps

module xqed_chan
  import xqed_pkg::*;
#(
  parameter int unsigned CNT_W = XQED_CNT_W
) (
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire xqed_enc_in_type    enc_in,
  input  wire logic               dir_invert,
  input  wire logic               err_clear,
  output logic signed [CNT_W-1:0] count,
  output logic                    err_flag,
  output xqed_evt_type            evt
);
  logic [1:0]               sx_reg, sx_next;
  logic [1:0]               sb_reg, sb_next;
  logic                     a_prev_reg, a_prev_next;
  logic                     b_prev_reg, b_prev_next;
  logic                     x_prev_reg, x_prev_next;
  logic signed [CNT_W-1:0]  cnt_reg, cnt_next;
  logic                     err_reg, err_next;
  xqed_evt_type             evt_reg, evt_next;
  logic                     a_now;
  logic                     b_now;
  logic                     x_now;
  logic                     fwd;
  logic                     both_moved;

  // two-stage synchronisers; only the second stage is ever looked at
  always_comb begin
    sx_next = {sx_reg[0], enc_in.xor_line};
    sb_next = {sb_reg[0], enc_in.chan_b};
  end

  assign x_now = sx_reg[1];
  assign b_now = sb_reg[1];
  assign a_now = x_now ^ b_now;
  // a and b both moved in one sample: xor steady, step lost
  assign both_moved = (a_now != a_prev_reg) && (b_now != b_prev_reg);

  // b leads a: after b moves a copies b, so new a equals new b when a moves on a forward step
  always_comb begin
    a_prev_next = a_now;
    b_prev_next = b_now;
    x_prev_next = x_now;
    cnt_next    = cnt_reg;
    err_next    = err_reg;
    evt_next    = '0;
    fwd         = 1'b0;
    if (err_clear) begin
      err_next = 1'b0;
    end
    // each sample is compared, so one edge per clock is never missed
    if (x_now != x_prev_reg) begin
      fwd = (a_now != a_prev_reg) ? (a_now == b_now) : (a_now != b_now);
      if (dir_invert) begin
        fwd = ~fwd;
      end
      if (fwd) begin
        cnt_next = cnt_reg + CNT_W'(1);
        evt_next.fwd_step = 1'b1;
      end else begin
        cnt_next = cnt_reg - CNT_W'(1);
        evt_next.rev_step = 1'b1;
      end
    end else if ((a_now != a_prev_reg) && (b_now != b_prev_reg)) begin
      // both moved: xor unchanged, step lost; set wins over clear
      err_next = 1'b1;
      evt_next.err_pulse = 1'b1;
    end
  end

  // registers only; the async reset loads constants alone
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sx_reg     <= XQED_SYNC_RST;
      sb_reg     <= XQED_SYNC_RST;
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      x_prev_reg <= 1'b0;
      cnt_reg    <= '0;
      err_reg    <= 1'b0;
      evt_reg    <= '0;
    end else begin
      sx_reg     <= sx_next;
      sb_reg     <= sb_next;
      a_prev_reg <= a_prev_next;
      b_prev_reg <= b_prev_next;
      x_prev_reg <= x_prev_next;
      cnt_reg    <= cnt_next;
      err_reg    <= err_next;
      evt_reg    <= evt_next;
    end
  end

  // every output comes straight from a flip-flop
  assign count    = cnt_reg;
  assign err_flag = err_reg;
  assign evt      = evt_reg;

  // a combined-line change always yields one step next cycle
  step_on_change_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (x_now != x_prev_reg) |=> (evt.fwd_step ^ evt.rev_step))
    else $error("combined change without a step");

  // forward step adds exactly one
  count_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    evt.fwd_step |-> (count == $past(count) + CNT_W'(1)))
    else $error("forward step did not add one");

  // reverse step takes exactly one
  count_down_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    evt.rev_step |-> (count == $past(count) - CNT_W'(1)))
    else $error("reverse step did not subtract one");

  // no step, no movement of the count
  count_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !(evt.fwd_step || evt.rev_step) |-> $stable(count))
    else $error("count moved without a step");

  // the pulse and the sticky flag rise together
  err_sticky_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    evt.err_pulse |-> err_flag)
    else $error("error event not flagged");

  // rebuilt a tracks the board lines two samples back; needs lines low in reset
  a_rebuild_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (a_now == $past(enc_in.xor_line ^ enc_in.chan_b, 2)))
    else $error("channel a rebuild wrong");

  // b moving away from a's level is a forward step
  fwd_dir_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((x_now != x_prev_reg) && !dir_invert && (b_now != b_prev_reg) && (a_now != b_now))
    |=> evt.fwd_step)
    else $error("b leading a not counted forward");

  // a moving onto b's level completes a forward step
  fwd_a_move_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((x_now != x_prev_reg) && !dir_invert && (a_now != a_prev_reg) && (a_now == b_now))
    |=> evt.fwd_step)
    else $error("a following b not counted forward");

  // reversed-output build flips the same pattern to reverse
  inv_dir_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((x_now != x_prev_reg) && dir_invert && (b_now != b_prev_reg) && (a_now != b_now))
    |=> evt.rev_step)
    else $error("inverted direction not applied");

  // a lost step must raise the pulse and the flag
  err_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((x_now == x_prev_reg) && both_moved) |=> (evt.err_pulse && err_flag))
    else $error("double change not flagged");

  // clear wins only when no new double change arrives
  err_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (err_clear && !both_moved) |=> !err_flag)
    else $error("error flag not cleared");

  // with no line movement nothing at all is reported
  idle_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((x_now == x_prev_reg) && !both_moved) |=> (evt == '0))
    else $error("event without line movement");

  fwd_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) evt.fwd_step);
  rev_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) evt.rev_step);
  err_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) evt.err_pulse);
  clr_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) err_clear && err_flag);
endmodule // xqed_chan

module xqed_top
  import xqed_pkg::*;
#(
  parameter int unsigned CNT_W = XQED_CNT_W
) (
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire xqed_enc_in_type    left_enc,
  input  wire xqed_enc_in_type    right_enc,
  input  wire logic               dir_invert,
  input  wire logic               left_err_clear,
  input  wire logic               right_err_clear,
  output logic signed [CNT_W-1:0] left_count,
  output logic signed [CNT_W-1:0] right_count,
  output logic                    left_err,
  output logic                    right_err,
  output xqed_evt_type            left_evt,
  output xqed_evt_type            right_evt
);
  // one decoder per drive motor, sharing only clock, reset and dir_invert
  xqed_chan #(.CNT_W(CNT_W)) u_left (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .enc_in     (left_enc),
    .dir_invert (dir_invert),
    .err_clear  (left_err_clear),
    .count      (left_count),
    .err_flag   (left_err),
    .evt        (left_evt)
  );

  xqed_chan #(.CNT_W(CNT_W)) u_right (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .enc_in     (right_enc),
    .dir_invert (dir_invert),
    .err_clear  (right_err_clear),
    .count      (right_count),
    .err_flag   (right_err),
    .evt        (right_evt)
  );
endmodule // xqed_top

/* xqed_enc_model.sv */
// hall sensor pair model for one motor encoder
`timescale 1ns/1ps

module xqed_enc_model
  import xqed_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [2:0] cmd,
  output xqed_enc_in_type enc
);
  logic a_reg = 1'b0;
  logic b_reg = 1'b0;

  // cmd = {both lines, reverse, forward}; one line moves per step
  always @(posedge ref_clk) begin
    if (cmd[2]) begin
      a_reg <= ~a_reg;
      b_reg <= ~b_reg;
    end else if (cmd[0]) begin
      if (a_reg == b_reg) b_reg <= ~b_reg;
      else a_reg <= ~a_reg;
    end else if (cmd[1]) begin
      if (a_reg == b_reg) a_reg <= ~a_reg;
      else b_reg <= ~b_reg;
    end
  end

  // board merges the channels before the pins
  assign enc = '{xor_line: a_reg ^ b_reg, chan_b: b_reg};
endmodule // xqed_enc_model

/* xqed_top_tb.sv */
// self-checking bench for the dual encoder decoder
`timescale 1ns/1ps

module xqed_top_tb
  import xqed_pkg::*;
;
  logic                         ref_clk    = 1'b0;
  logic                         sys_rst    = 1'b1;
  logic                         dir_invert = 1'b0;
  localparam int                GEAR_RATIO = 3; // whole ratio keeps one wheel turn short
  logic                         l_clr      = 1'b0;
  logic                         r_clr      = 1'b0;
  logic [2:0]                   l_cmd      = 3'h0;
  logic [2:0]                   r_cmd      = 3'h0;
  xqed_enc_in_type              l_enc;
  xqed_enc_in_type              r_enc;
  logic signed [XQED_CNT_W-1:0] l_cnt;
  logic signed [XQED_CNT_W-1:0] r_cnt;
  logic                         l_err;
  logic                         r_err;
  xqed_evt_type                 l_evt;
  xqed_evt_type                 r_evt;
  int                           l_fwd_n    = 0;
  int                           l_rev_n    = 0;
  int                           l_err_n    = 0;
  int                           r_fwd_n    = 0;
  int                           r_rev_n    = 0;
  int                           r_err_n    = 0;
  int                           fail_count = 0;
  int                           num_checks = 0;

  xqed_enc_model xqed_enc_model_l_i (.ref_clk(ref_clk), .cmd(l_cmd), .enc(l_enc));
  xqed_enc_model xqed_enc_model_r_i (.ref_clk(ref_clk), .cmd(r_cmd), .enc(r_enc));
  xqed_top xqed_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .left_enc(l_enc),
    .right_enc(r_enc), .dir_invert(dir_invert), .left_err_clear(l_clr),
    .right_err_clear(r_clr), .left_count(l_cnt), .right_count(r_cnt), .left_err(l_err),
    .right_err(r_err), .left_evt(l_evt), .right_evt(r_evt));

  // clock, 50 ns period
  initial forever #25 ref_clk = ~ref_clk;

  // tally event pulses at mid-cycle, where the registered outputs stand settled
  always @(negedge ref_clk) begin
    if (l_evt.fwd_step) l_fwd_n++;
    if (l_evt.rev_step) l_rev_n++;
    if (l_evt.err_pulse) l_err_n++;
    if (r_evt.fwd_step) r_fwd_n++;
    if (r_evt.rev_step) r_rev_n++;
    if (r_evt.err_pulse) r_err_n++;
  end

  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_cnt({31'h0, got}, {31'h0, exp});
  endtask

  // n steps back to back, one per clock, then settle past the 3-cycle latency
  task automatic run(input logic side, input logic [2:0] cmd, input int n);
    @(posedge ref_clk);
    if (side) r_cmd <= cmd;
    else l_cmd <= cmd;
    repeat (n) @(posedge ref_clk);
    l_cmd <= 3'h0;
    r_cmd <= 3'h0;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // reset leaves counts and flags of both channels at zero
  task automatic scn_reset();
    repeat (4) @(posedge ref_clk);
    chk_cnt(l_cnt, 32'h0);
    chk_cnt(r_cnt, 32'h0);
    chk_flag(l_err, 1'b0);
    chk_flag(r_err, 1'b0);
  endtask

  // one motor shaft turn forward on the left, every edge counted
  task automatic scn_shaft_turn();
    run(1'b0, 3'h1, XQED_CPR_MOTOR);
    chk_cnt(l_cnt, 32'(XQED_CPR_MOTOR));
    chk_cnt(l_fwd_n, 32'(XQED_CPR_MOTOR));
    chk_cnt(r_cnt, 32'h0);
  endtask

  // one wheel turn is the gear ratio times the shaft count
  task automatic scn_wheel_turn();
    run(1'b0, 3'h1, GEAR_RATIO * XQED_CPR_MOTOR);
    chk_cnt(l_cnt, 32'((GEAR_RATIO + 1) * XQED_CPR_MOTOR));
  endtask

  // right motor runs backward: a leads b, count falls, left untouched
  task automatic scn_reverse();
    run(1'b1, 3'h2, 5);
    chk_cnt(r_cnt, 32'hFFFFFFFB);
    chk_cnt(r_rev_n, 32'h5);
    chk_cnt(l_cnt, 32'h30);
  endtask

  // reversed-output build: both channels read the opposite sense
  task automatic scn_invert();
    dir_invert <= 1'b1;
    run(1'b0, 3'h1, 4);
    chk_cnt(l_cnt, 32'h2C);
    chk_cnt(l_rev_n, 32'h4);
    run(1'b1, 3'h2, 3);
    chk_cnt(r_cnt, 32'hFFFFFFFE);
    chk_cnt(r_fwd_n, 32'h3);
    dir_invert <= 1'b0;
  endtask

  // both lines flip in one sample: step lost, count held, flag raised
  task automatic scn_double();
    run(1'b0, 3'h4, 1);
    run(1'b1, 3'h4, 1);
    chk_flag(l_err, 1'b1);
    chk_flag(r_err, 1'b1);
    chk_cnt(l_err_n, 32'h1);
    chk_cnt(r_err_n, 32'h1);
    chk_cnt(l_cnt, 32'h2C);
    chk_cnt(r_cnt, 32'hFFFFFFFE);
  endtask

  // each clear acts on its own channel only; counting resumes after
  task automatic scn_clear();
    l_clr <= 1'b1;
    @(posedge ref_clk);
    l_clr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_flag(l_err, 1'b0);
    chk_flag(r_err, 1'b1);
    r_clr <= 1'b1;
    @(posedge ref_clk);
    r_clr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_flag(r_err, 1'b0);
    run(1'b0, 3'h1, 2);
    run(1'b1, 3'h1, 2);
    chk_cnt(l_cnt, 32'h2E);
    chk_cnt(r_cnt, 32'h0);
    chk_cnt(l_fwd_n, 32'h32);
    chk_cnt(r_fwd_n, 32'h5);
  endtask

  // main sequence: inputs stay low through reset, then each scenario in turn
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    scn_reset();
    scn_shaft_turn();
    scn_wheel_turn();
    scn_reverse();
    scn_invert();
    scn_double();
    scn_clear();
    wrap_up();
  end

  // hang guard, far beyond the roughly 150 cycles needed
  initial begin
    #(3000 * 50);
    fail_count++;
    wrap_up();
  end
endmodule // xqed_top_tb
